// ---- hw/pdc_pkg.sv ----
// package of constants and types for the pcie device control register block
package pdc_pkg;

    // register placement and value after reset
    localparam logic [11:0] PDC_CTRL_OFFSET = 12'h098;
    localparam logic [15:0] PDC_CTRL_RESET  = 16'h2800;
    // writable bits; 9, 8 and 4 are hardwired zero
    localparam logic [15:0] PDC_CTRL_RW_MASK = 16'hfcef;

    // field positions
    localparam int PDC_RETRY_BIT  = 15;
    localparam int PDC_MAX_READ_REQUEST_SIZE_LSB   = 12;
    localparam int PDC_NS_BIT     = 11;
    localparam int PDC_AUX_BIT    = 10;
    localparam int PDC_PFE_BIT    = 9;
    localparam int PDC_EXTENDED_TAG_ENABLE_BIT   = 8;
    localparam int PDC_MPS_LSB    = 5;
    localparam int PDC_RO_BIT     = 4;
    localparam int PDC_UR_BIT     = 3;
    localparam int PDC_FATAL_BIT  = 2;
    localparam int PDC_NFATAL_BIT = 1;
    localparam int PDC_COR_BIT    = 0;

    // size codes: 128 bytes shifted left by the code, 6 and 7 reserved
    localparam logic [12:0] PDC_SIZE_BASE   = 13'h0080;
    localparam logic [2:0]  PDC_SIZE_MAXCOD = 3'h5;
    localparam logic [7:0]  PDC_CLS_BYTES_PER_UNIT = 8'h04;

    // retry time-out for forwarded configuration requests
    localparam int PDC_CLK_MHZ        = 10;
    localparam int PDC_CFG_TIMEOUT_US = 50;
    localparam int PDC_CFG_TIMEOUT_CYC = PDC_CFG_TIMEOUT_US * PDC_CLK_MHZ;
    localparam logic [9:0] PDC_TO_LAST = 10'(PDC_CFG_TIMEOUT_CYC - 1);

    // stored control fields
    typedef struct packed {
        logic       config_retry_completion_enable;
        logic [2:0] max_read_request_size;
        logic       no_snoop_attribute_enable;
        logic       aux_power_pm_enable;
        logic       phantom_function_enable;
        logic       extended_tag_enable;
        logic [2:0] max_payload_size;
        logic       relaxed_ordering_enable;
        logic       unsupported_request_report_enable;
        logic       fatal_error_report_enable;
        logic       nonfatal_error_report_enable;
        logic       correctable_error_report_enable;
    } pdc_ctrl_t;

    // configuration access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } pdc_cfg_req_t;

    // retry watchdog states
    typedef enum logic [1:0] {
        PDC_IDLE = 2'b01,
        PDC_WAIT = 2'b10
    } pdc_state_t;

endpackage

// ---- hw/pdc_device_control.sv ----
// device control register with its retry, sizing, no-snoop and error message logic
`timescale 1ns/1ps

module pdc_device_control
    import pdc_pkg::*;
(
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // configuration access port
    input  wire pdc_cfg_req_t cfg_req,
    output logic [15:0]       cfg_rdata,
    output logic              cfg_rvalid,
    // forwarded configuration requests to the secondary side
    input  wire logic         fwd_cfg_start,
    input  wire logic         fwd_cfg_done,
    output logic              retry_cpl,
    // read sizing
    input  wire logic [7:0]   cache_line_size,
    output logic [12:0]       max_read_request_bytes,
    output logic [12:0]       prefetch_bytes,
    output logic [12:0]       max_payload_bytes,
    // upstream request attribute
    input  wire logic         up_req_valid,
    input  wire logic         up_req_vc_nonzero,
    output logic              up_req_attr_valid,
    output logic              up_req_no_snoop,
    // error events and messages
    input  wire logic         ur_received,
    input  wire logic         fatal_event,
    input  wire logic         nonfatal_event,
    input  wire logic         correctable_event,
    output logic              err_fatal_msg,
    output logic              err_nonfatal_msg,
    output logic              err_cor_msg
);

    pdc_ctrl_t   ctrl_q;          // stored register image
    logic [15:0] ctrl_img;        // image as seen on the bus
    logic        hit;             // access addresses this register
    logic [15:0] wmask;           // writable bits under the byte enables
    pdc_state_t  state_q;         // retry watchdog state
    logic [9:0]  to_cnt_q;        // cycles spent waiting
    logic [12:0] max_read_request_size_bytes;      // decoded read request size
    logic [12:0] cls_bytes;       // cache line size in bytes

    assign ctrl_img = ctrl_q;
    assign hit      = (cfg_req.addr == PDC_CTRL_OFFSET);
    assign wmask    = PDC_CTRL_RW_MASK & {{8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};

    // decode a size code; reserved codes fall back to the smallest size,
    // which can never overrun a completer
    function automatic logic [12:0] size_bytes(input logic [2:0] code);
        if (code > PDC_SIZE_MAXCOD) begin
            size_bytes = PDC_SIZE_BASE;
        end else begin
            size_bytes = PDC_SIZE_BASE << code;
        end
    endfunction

    assign max_read_request_size_bytes = size_bytes(ctrl_q.max_read_request_size);
    assign cls_bytes  = 13'(cache_line_size) * 13'(PDC_CLS_BYTES_PER_UNIT);

    // register writes; masked merge keeps hardwired bits at zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= pdc_ctrl_t'(PDC_CTRL_RESET);
        end else if (cfg_req.wr && hit) begin
            ctrl_q <= pdc_ctrl_t'((ctrl_img & ~wmask) | (cfg_req.wdata & wmask));
        end
    end

    // register reads; other offsets belong to neighbouring registers and read zero here
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_rdata  <= 16'h0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_req.rd;
            if (cfg_req.rd && hit) begin
                cfg_rdata <= ctrl_img;
            end else begin
                cfg_rdata <= 16'h0000;
            end
        end
    end

    // watchdog on forwarded configuration requests
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q   <= PDC_IDLE;
            to_cnt_q  <= 10'h000;
            retry_cpl <= 1'b0;
        end else begin
            retry_cpl <= 1'b0;
            case (state_q)
                PDC_IDLE: begin
                    to_cnt_q <= 10'h000;
                    if (fwd_cfg_start) begin
                        state_q <= PDC_WAIT;
                    end
                end
                PDC_WAIT: begin
                    if (fwd_cfg_done) begin
                        // completion arrived in time, no retry status
                        state_q <= PDC_IDLE;
                    end else if (to_cnt_q == PDC_TO_LAST) begin
                        state_q   <= PDC_IDLE;
                        retry_cpl <= ctrl_q.config_retry_completion_enable;
                    end else begin
                        to_cnt_q <= to_cnt_q + 10'h001;
                    end
                end
                default: begin
                    state_q <= PDC_IDLE;
                end
            endcase
        end
    end

    // sizes seen by the transaction layer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            max_read_request_bytes <= 13'h0000;
            prefetch_bytes         <= 13'h0000;
            max_payload_bytes      <= 13'h0000;
        end else begin
            max_read_request_bytes <= max_read_request_size_bytes;
            max_payload_bytes      <= size_bytes(ctrl_q.max_payload_size);
            // a cache line that fits under the request limit sets the fetch size
            if (cls_bytes != 13'h0000 && cls_bytes <= max_read_request_size_bytes) begin
                prefetch_bytes <= cls_bytes;
            end else begin
                prefetch_bytes <= max_read_request_size_bytes;
            end
        end
    end

    // no-snoop attribute for upstream memory requests
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            up_req_attr_valid <= 1'b0;
            up_req_no_snoop   <= 1'b0;
        end else begin
            up_req_attr_valid <= up_req_valid;
            // vc0 traffic keeps no-snoop clear
            up_req_no_snoop   <= up_req_valid && up_req_vc_nonzero
                                 && ctrl_q.no_snoop_attribute_enable;
        end
    end

    // error messages, gated by their enables
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            err_fatal_msg    <= 1'b0;
            err_nonfatal_msg <= 1'b0;
            err_cor_msg      <= 1'b0;
        end else begin
            err_fatal_msg    <= fatal_event && ctrl_q.fatal_error_report_enable;
            err_nonfatal_msg <= (ur_received && ctrl_q.unsupported_request_report_enable)
                                || (nonfatal_event && ctrl_q.nonfatal_error_report_enable);
            err_cor_msg      <= correctable_event && ctrl_q.correctable_error_report_enable;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_waiting_out;
        state_q == PDC_WAIT && !fwd_cfg_done && to_cnt_q == PDC_TO_LAST;
    endsequence

    property p_reset_value;
        $fell(rst) |-> ctrl_img == PDC_CTRL_RESET;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("control register reset value wrong");

    property p_ro_bits;
        cfg_req.wr && hit |=> ctrl_img[PDC_PFE_BIT] == 1'b0 && ctrl_img[PDC_EXTENDED_TAG_ENABLE_BIT] == 1'b0
                              && ctrl_img[PDC_RO_BIT] == 1'b0;
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("hardwired bit became set");

    property p_full_write;
        cfg_req.wr && hit && cfg_req.be == 2'b11 |=> ctrl_img == ($past(cfg_req.wdata) & PDC_CTRL_RW_MASK);
    endproperty
    a_full_write: assert property (p_full_write) else $error("write did not land in read-write bits");

    property p_retry_fire;
        s_waiting_out |=> retry_cpl == $past(ctrl_q.config_retry_completion_enable) ##0 state_q == PDC_IDLE;
    endproperty
    a_retry_fire: assert property (p_retry_fire) else $error("retry completion not issued on time-out");

    property p_retry_cause;
        retry_cpl |-> $past(ctrl_q.config_retry_completion_enable) && $past(state_q) == PDC_WAIT;
    endproperty
    a_retry_cause: assert property (p_retry_cause) else $error("retry completion without enable");

    property p_no_snoop;
        up_req_valid |=> up_req_attr_valid
                         && up_req_no_snoop == $past(up_req_vc_nonzero && ctrl_q.no_snoop_attribute_enable);
    endproperty
    a_no_snoop: assert property (p_no_snoop) else $error("no-snoop attribute wrong");

    property p_ur_report;
        ur_received && ctrl_q.unsupported_request_report_enable |=> err_nonfatal_msg;
    endproperty
    a_ur_report: assert property (p_ur_report) else $error("unsupported request not reported");

    property p_nonfatal_cause;
        err_nonfatal_msg |-> $past((ur_received && ctrl_q.unsupported_request_report_enable)
                                   || (nonfatal_event && ctrl_q.nonfatal_error_report_enable));
    endproperty
    a_nonfatal_cause: assert property (p_nonfatal_cause) else $error("nonfatal message without cause");

    property p_fatal;
        fatal_event |=> err_fatal_msg == $past(ctrl_q.fatal_error_report_enable);
    endproperty
    a_fatal: assert property (p_fatal) else $error("fatal message gating wrong");

    property p_cor;
        correctable_event ##1 !correctable_event |-> err_cor_msg == $past(ctrl_q.correctable_error_report_enable);
    endproperty
    a_cor: assert property (p_cor) else $error("correctable message gating wrong");

    property p_payload;
        // sizes load on every edge with reset low, first on the edge right after release, so skip that edge
        ##1 !$past(rst) && $stable(ctrl_q) |-> max_payload_bytes == size_bytes($past(ctrl_q.max_payload_size));
    endproperty
    a_payload: assert property (p_payload) else $error("payload size decode wrong");

endmodule

// ---- tb/pdc_host_model.sv ----
// host-side model that issues configuration accesses to the control register
`timescale 1ns/1ps

module pdc_host_model
    import pdc_pkg::*;
(
    // clock
    input  wire logic         ref_clk,
    // configuration access towards the device
    output pdc_cfg_req_t      cfg_req,
    input  wire logic [15:0]  cfg_rdata,
    input  wire logic         cfg_rvalid
);
    // idle request from time zero
    initial cfg_req = '0;

    // one-cycle write; the host chooses the size codes it programs
    task automatic cfg_wr(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
        @(posedge ref_clk) cfg_req <= {1'b1, 1'b0, a, be, d};
        // released lines show the inverse, so stale data never looks valid
        @(posedge ref_clk) cfg_req <= {2'b00, ~a, ~be, ~d};
    endtask

    // one-cycle read; data taken at the edge that answers it
    task automatic cfg_rd(input logic [11:0] a, output logic [15:0] d, output logic v);
        @(posedge ref_clk) cfg_req <= {1'b0, 1'b1, a, 2'h3, 16'h0000};
        @(posedge ref_clk) cfg_req <= {2'b00, ~a, 2'h0, 16'hffff};
        #1;
        d = cfg_rdata;
        v = cfg_rvalid;
    endtask
endmodule

// ---- tb/test_pdc_device_control.sv ----
// self-checking bench for the device control register block
`timescale 1ns/1ps

module test_pdc_device_control;
    import pdc_pkg::*;
    // clock, reset and stimulus
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    pdc_cfg_req_t cfg_req;
    logic [15:0]  cfg_rdata;
    logic         cfg_rvalid, retry_cpl, up_req_attr_valid, up_req_no_snoop;
    logic         fwd_cfg_start = 1'b0, fwd_cfg_done = 1'b0;
    logic         up_req_valid = 1'b0, up_req_vc_nonzero = 1'b0;
    logic         ur_received = 1'b0, fatal_event = 1'b0;
    logic         nonfatal_event = 1'b0, correctable_event = 1'b0;
    logic         err_fatal_msg, err_nonfatal_msg, err_cor_msg;
    logic [7:0]   cache_line_size = 8'h00;
    logic [12:0]  mrb, pfb, mpb;
    // bench bookkeeping; img mirrors the expected register contents
    int           mismatches = 0, num_checks = 0, n_retry = 0, seed = 69225;
    logic [15:0]  img, rd_d, d;
    logic [31:0]  r;
    logic [3:0]   ev;
    logic [1:0]   be;
    logic         rv;

    always #50 ref_clk = ~ref_clk;

    pdc_device_control pdc_device_control_inst (
        .ref_clk(ref_clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .fwd_cfg_start(fwd_cfg_start), .fwd_cfg_done(fwd_cfg_done),
        .retry_cpl(retry_cpl), .cache_line_size(cache_line_size), .max_read_request_bytes(mrb),
        .prefetch_bytes(pfb), .max_payload_bytes(mpb), .up_req_valid(up_req_valid),
        .up_req_vc_nonzero(up_req_vc_nonzero), .up_req_attr_valid(up_req_attr_valid),
        .up_req_no_snoop(up_req_no_snoop), .ur_received(ur_received), .fatal_event(fatal_event),
        .nonfatal_event(nonfatal_event), .correctable_event(correctable_event),
        .err_fatal_msg(err_fatal_msg), .err_nonfatal_msg(err_nonfatal_msg), .err_cor_msg(err_cor_msg));

    pdc_host_model pdc_host_model_inst (
        .ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

    // count retry completions so stray ones are caught later
    always @(posedge ref_clk) if (retry_cpl === 1'b1) n_retry <= n_retry + 1;

    // compare and report
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // decoded size; reserved codes fall back to the smallest size
    function automatic logic [12:0] sz(input logic [2:0] c);
        return (c <= 3'h5) ? (13'h0080 << c) : 13'h0080;
    endfunction

    // fetch size: cache line bytes when they fit under the read limit
    function automatic logic [12:0] pf(input logic [7:0] cls, input logic [12:0] m);
        logic [12:0] b;
        b = {3'h0, cls, 2'h0};
        return (b != 13'h0 && b <= m) ? b : m;
    endfunction

    // one forwarded request; done_at 0 means the secondary side never answers
    task automatic retry(input logic en, input int done_at);
        int n0;
        d = {en, img[14:0]};
        pdc_host_model_inst.cfg_wr(PDC_CTRL_OFFSET, 2'h3, d);
        img = d & PDC_CTRL_RW_MASK;
        n0 = n_retry;
        @(posedge ref_clk) fwd_cfg_start <= 1'b1;
        @(posedge ref_clk) fwd_cfg_start <= 1'b0;
        for (int i = 1; i <= 520; i++) begin
            @(posedge ref_clk) fwd_cfg_done <= (i == done_at);
            #1;
            // the pulse is launched by the edge on which the counter reads its last value
            if (i >= PDC_CFG_TIMEOUT_CYC - 1 && i <= PDC_CFG_TIMEOUT_CYC + 1)
                chk("retry_cpl", 16'(en && done_at == 0 && i == PDC_CFG_TIMEOUT_CYC), 16'(retry_cpl));
        end
        chk("retry_count", 16'(en && done_at == 0), 16'(n_retry - n0));
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        img = PDC_CTRL_RESET;
        pdc_host_model_inst.cfg_rd(PDC_CTRL_OFFSET, rd_d, rv);
        chk("reset_image", 16'h2800, rd_d);
        chk("max_read_request_size_reset", 16'd512, 16'(mrb));
        chk("mps_reset", 16'd128, 16'(mpb));
        chk("pf_reset", 16'(pf(8'h00, 13'd512)), 16'(pfb));
        // unmapped place: write ignored, read answers zero with valid
        pdc_host_model_inst.cfg_wr(12'h09a, 2'h3, 16'hffff);
        pdc_host_model_inst.cfg_rd(12'h09a, rd_d, rv);
        chk("unmapped", 16'h0000, rd_d);
        chk("unmapped_rvalid", 16'h0001, 16'(rv));
        // the stray write must not have reached this register
        pdc_host_model_inst.cfg_rd(PDC_CTRL_OFFSET, rd_d, rv);
        chk("unmapped_wr", PDC_CTRL_RESET, rd_d);
        for (int k = 0; k < 40; k++) begin
            r = $random(seed);
            d = (k == 0) ? 16'hffff : r[15:0];
            be = (k == 0) ? 2'h3 : r[17:16];
            pdc_host_model_inst.cfg_wr(PDC_CTRL_OFFSET, be, d);
            img = ((img & ~{{8{be[1]}}, {8{be[0]}}}) | (d & {{8{be[1]}}, {8{be[0]}}})) & PDC_CTRL_RW_MASK;
            pdc_host_model_inst.cfg_rd(PDC_CTRL_OFFSET, rd_d, rv);
            chk("ctrl", img, rd_d);
            chk("rvalid", 16'h0001, 16'(rv));
            ev = r[29:26];
            @(posedge ref_clk) begin
                {ur_received, fatal_event, nonfatal_event, correctable_event} <= ev;
                up_req_valid <= 1'b1;
                up_req_vc_nonzero <= r[30];
                cache_line_size <= r[25:18];
            end
            @(posedge ref_clk) begin
                {ur_received, fatal_event, nonfatal_event, correctable_event} <= 4'h0;
                up_req_valid <= 1'b0;
            end
            #1;
            chk("attr", {15'h0001, r[30] & img[11]}, {15'(up_req_attr_valid), up_req_no_snoop});
            chk("fatal_msg", 16'(ev[2] & img[2]), 16'(err_fatal_msg));
            chk("nonfatal_msg", 16'((ev[3] & img[3]) | (ev[1] & img[1])), 16'(err_nonfatal_msg));
            chk("cor_msg", 16'(ev[0] & img[0]), 16'(err_cor_msg));
            @(posedge ref_clk);
            #1;
            chk("max_read_request_size", 16'(sz(img[14:12])), 16'(mrb));
            chk("mps", 16'(sz(img[7:5])), 16'(mpb));
            chk("prefetch", 16'(pf(r[25:18], sz(img[14:12]))), 16'(pfb));
        end
        // reset again mid-run: every field returns to its value after reset
        @(posedge ref_clk) rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        img = PDC_CTRL_RESET;
        pdc_host_model_inst.cfg_rd(PDC_CTRL_OFFSET, rd_d, rv);
        chk("reset_again", PDC_CTRL_RESET, rd_d);
        chk("max_read_request_size_again", 16'd512, 16'(mrb));
        chk("mps_again", 16'd128, 16'(mpb));
        retry(1'b1, 0);
        retry(1'b1, 100);
        retry(1'b0, 0);
        print_verdict();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        $display("[FAIL] watchdog expected finish seen timeout");
        print_verdict();
    end
endmodule
